/* shared/acr_cfg.svh */
// Register map, field positions and pattern constants for the ADC config slice
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// Bus and word widths
`define ACR_ADDR_W      8
`define ACR_DATA_W      32
`define ACR_WORD_W      14

// Register indexes; byte address is four times the index
`define ACR_IDX_SRC     6'h00
`define ACR_IDX_STAT    6'h01
`define ACR_IDX_GAIN    6'h04
`define ACR_IDX_ULO     6'h0b
`define ACR_IDX_UHI     6'h0c
`define ACR_ADDR_SRC    ({`ACR_IDX_SRC, 2'b00})
`define ACR_ADDR_STAT   ({`ACR_IDX_STAT, 2'b00})
`define ACR_ADDR_GAIN   ({`ACR_IDX_GAIN, 2'b00})
`define ACR_ADDR_ULO    ({`ACR_IDX_ULO, 2'b00})
`define ACR_ADDR_UHI    ({`ACR_IDX_UHI, 2'b00})

// Field positions
`define ACR_GAIN_LSB    2
`define ACR_GAIN_MSB    6
`define ACR_SRC_LSB     5
`define ACR_SRC_MSB     7
`define ACR_FMT_BIT     9
`define ACR_ULO_MSB     10
`define ACR_UHI_MSB     2
`define ACR_STAT_OK_BIT 3
`define ACR_STAT_TG_BIT 4

// Clock buffer gain codes
`define ACR_GAIN_C0     5'h18
`define ACR_GAIN_C1     5'h00
`define ACR_GAIN_C2     5'h0c
`define ACR_GAIN_C3     5'h0a
`define ACR_GAIN_C4     5'h09
`define ACR_GAIN_C5     5'h08

// Output source codes
`define ACR_SRC_NORMAL  3'h0
`define ACR_SRC_ZEROS   3'h1
`define ACR_SRC_ONES    3'h2
`define ACR_SRC_TOGGLE  3'h3
`define ACR_SRC_UNUSED  3'h4
`define ACR_SRC_CUSTOM  3'h5
`define ACR_SRC_ALIGN   3'h6
`define ACR_SRC_SYNC    3'h7

// Pattern words
`define ACR_TOGGLE_WORD 14'h1555
`define ACR_ALIGN_WORD  14'h2aaa
`define ACR_SYNC_WORD   14'h3f80

`endif

/* shared/acr_pkg.sv */
// Types shared by the ADC config slice
`default_nettype none
`include "acr_cfg.svh"

package acr_pkg;

  // Whole state of the register slice
  typedef struct packed {
    logic [2:0]               src;
    logic                     output_number_coding;
    logic [4:0]               gain;
    logic [10:0]              ulo;
    logic [2:0]               uhi;
    logic [2:0]               gain_step;
    logic                     gain_ok;
    logic                     toggle_ph;
    logic                     pready;
    logic                     pslverr;
    logic [`ACR_DATA_W-1:0]   prdata;
    logic                     out_valid;
    logic [`ACR_WORD_W-1:0]   out_word;
  } acr_state_s;

  typedef logic [2:0] acr_step_t;

endpackage

`default_nettype wire

/* hw/acr_gain_decode.sv */
// Clock buffer gain code to gain step decoder
`timescale 1ns/1ns
`default_nettype none
`include "acr_cfg.svh"

module acr_gain_decode (
  input  wire logic [4:0]      code, // Gain field
  output acr_pkg::acr_step_t   step, // Gain step 0..5
  output logic                 ok    // Code is a listed one
);

  // Map each listed code to its step
  always_comb begin
    ok = 1'b1;
    case (code)
      `ACR_GAIN_C0: step = 3'h0;
      `ACR_GAIN_C1: step = 3'h1;
      `ACR_GAIN_C2: step = 3'h2;
      `ACR_GAIN_C3: step = 3'h3;
      `ACR_GAIN_C4: step = 3'h4;
      `ACR_GAIN_C5: step = 3'h5;
      default: begin
        step = 3'h1;
        ok   = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

/* hw/acr_regs.sv */
// APB register slice with clock gain decode and output test patterns
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "acr_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Hardware or software reset clears all four config registers to zero
// - Gain field bits 6..2, code 11000 gives the lowest gain step
// - Gain code 00000 selects step one, the reset setting
// - Codes 01100, 01010, 01001, 01000 select steps two to five
// - Source field bits 7..5 at 000 passes conversion results
// - Source 001 outputs all zeros, 010 outputs all ones
// - Source 011 selects toggle pattern; 100 is unused
// - Source 101 outputs the user word from both user registers
// - Source 110 outputs an alternating one-zero serial stream
// - Source 111 outputs the synchronisation pattern
// - Bit 9 picks two's complement at zero, straight binary at one
// - Register 0x0B holds the user word low eleven bits
// - Low three bits of register 0x0C give the user word top bits
module acr_regs #(
  parameter logic [`ACR_WORD_W-1:0] SYNC_WORD = `ACR_SYNC_WORD // Sync word
) (
  input  wire logic                     clock,           // 100 MHz clock
  input  wire logic                     reset,           // Sync reset, high
  input  wire logic                     soft_reset,      // Software reset pulse
  input  wire logic                     psel,            // APB select
  input  wire logic                     penable,         // APB enable
  input  wire logic                     pwrite,          // APB write
  input  wire logic [`ACR_ADDR_W-1:0]   paddr,           // APB byte address
  input  wire logic [`ACR_DATA_W-1:0]   pwdata,          // APB write data
  input  wire logic [3:0]               pstrb,           // APB byte strobes
  output logic      [`ACR_DATA_W-1:0]   prdata,          // APB read data
  output logic                          pready,          // APB ready
  output logic                          pslverr,         // APB error
  input  wire logic                     sample_valid,    // Converter sample strobe
  input  wire logic [`ACR_WORD_W-1:0]   sample_data,     // Two's complement sample
  output logic                          out_valid,       // Output word strobe
  output logic      [`ACR_WORD_W-1:0]   out_word,        // Output word
  output logic      [2:0]               clk_gain_step,   // Clock buffer gain step
  output logic                          clk_gain_code_ok // Gain code is listed
);

  acr_pkg::acr_state_s       st_q;
  acr_pkg::acr_state_s       st_d;
  acr_pkg::acr_step_t        dec_step;
  logic                      dec_ok;
  logic [`ACR_DATA_W-1:0]    old_w;
  logic [`ACR_DATA_W-1:0]    mask_w;
  logic [`ACR_DATA_W-1:0]    new_w;
  logic                      hit;
  logic                      ro;

  //////////////////////////////////////////////////////////////////////////////
  // Gain decoder
  acr_gain_decode u_gain (
    .code (st_q.gain),
    .step (dec_step),
    .ok   (dec_ok)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read view of the addressed register
  always_comb begin
    old_w = '0;
    hit   = 1'b1;
    ro    = 1'b0;
    case (paddr)
      `ACR_ADDR_SRC: begin
        old_w[`ACR_SRC_MSB:`ACR_SRC_LSB] = st_q.src;
        old_w[`ACR_FMT_BIT]               = st_q.output_number_coding;
      end
      `ACR_ADDR_GAIN: begin
        old_w[`ACR_GAIN_MSB:`ACR_GAIN_LSB] = st_q.gain;
      end
      `ACR_ADDR_ULO: begin
        old_w[`ACR_ULO_MSB:0] = st_q.ulo;
      end
      `ACR_ADDR_UHI: begin
        old_w[`ACR_UHI_MSB:0] = st_q.uhi;
      end
      `ACR_ADDR_STAT: begin
        old_w[2:0]              = st_q.gain_step;
        old_w[`ACR_STAT_OK_BIT] = st_q.gain_ok;
        old_w[`ACR_STAT_TG_BIT] = st_q.toggle_ph;
        ro                      = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Byte-strobe merge of write data
  always_comb begin
    mask_w = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    new_w  = (old_w & ~mask_w) | (pwdata & mask_w);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    // APB: one wait state, then commit on the ready edge
    if (psel && penable && !st_q.pready) begin
      st_d.pready  = 1'b1;
      st_d.pslverr = !hit || (pwrite && ro);
      st_d.prdata  = (hit && !pwrite) ? old_w : '0;
    end else if (psel && penable && st_q.pready) begin
      st_d.pready  = 1'b0;
      st_d.pslverr = 1'b0;
      st_d.prdata  = '0;
      if (pwrite && hit && !ro) begin
        case (paddr)
          `ACR_ADDR_SRC: begin
            st_d.src                  = new_w[`ACR_SRC_MSB:`ACR_SRC_LSB];
            st_d.output_number_coding = new_w[`ACR_FMT_BIT];
          end
          `ACR_ADDR_GAIN: begin
            st_d.gain = new_w[`ACR_GAIN_MSB:`ACR_GAIN_LSB];
          end
          `ACR_ADDR_ULO: begin
            st_d.ulo = new_w[`ACR_ULO_MSB:0];
          end
          `ACR_ADDR_UHI: begin
            st_d.uhi = new_w[`ACR_UHI_MSB:0];
          end
          default: begin
            st_d.uhi = st_q.uhi;
          end
        endcase
      end
    end else begin
      st_d.pready  = 1'b0;
      st_d.pslverr = 1'b0;
    end
    // Software reset beats a write in the same cycle
    if (soft_reset) begin
      st_d.src                  = '0;
      st_d.output_number_coding = 1'b0;
      st_d.gain                 = '0;
      st_d.ulo                  = '0;
      st_d.uhi                  = '0;
      st_d.toggle_ph            = 1'b0;
    end
    // Registered gain decode
    st_d.gain_step = dec_step;
    st_d.gain_ok   = dec_ok;
    // Output word per sample
    st_d.out_valid = sample_valid;
    if (sample_valid) begin
      case (st_q.src)
        `ACR_SRC_NORMAL: begin
          st_d.out_word = {sample_data[`ACR_WORD_W-1] ^ st_q.output_number_coding,
                           sample_data[`ACR_WORD_W-2:0]};
        end
        `ACR_SRC_ZEROS: begin
          st_d.out_word = '0;
        end
        `ACR_SRC_ONES: begin
          st_d.out_word = '1;
        end
        `ACR_SRC_TOGGLE: begin
          st_d.out_word  = st_q.toggle_ph ? ~`ACR_TOGGLE_WORD : `ACR_TOGGLE_WORD;
          st_d.toggle_ph = ~st_q.toggle_ph;
        end
        `ACR_SRC_CUSTOM: begin
          st_d.out_word = {st_q.uhi, st_q.ulo};
        end
        `ACR_SRC_ALIGN: begin
          st_d.out_word = `ACR_ALIGN_WORD;
        end
        `ACR_SRC_SYNC: begin
          st_d.out_word = SYNC_WORD;
        end
        default: begin
          st_d.out_word = '0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign prdata           = st_q.prdata;
  assign pready           = st_q.pready;
  assign pslverr          = st_q.pslverr;
  assign out_valid        = st_q.out_valid;
  assign out_word         = st_q.out_word;
  assign clk_gain_step    = st_q.gain_step;
  assign clk_gain_code_ok = st_q.gain_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // Register write completing at an address
  sequence s_wr_done(logic [`ACR_ADDR_W-1:0] a);
    psel && penable && pready && pwrite && !pslverr && (paddr == a) &&
      (pstrb == 4'hf) && !soft_reset;
  endsequence

  // Two back-to-back toggle samples
  sequence s_tog_two;
    (st_q.src == `ACR_SRC_TOGGLE) && sample_valid && !soft_reset
      ##1 (st_q.src == `ACR_SRC_TOGGLE) && sample_valid && !soft_reset;
  endsequence

  property p_soft_clear;
    soft_reset |=> (st_q.src == 3'h0) && (st_q.gain == 5'h00) && (st_q.ulo == 11'h000) &&
      (st_q.uhi == 3'h0) && !st_q.output_number_coding;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("config not cleared by soft reset");

  property p_gain_min;
    (st_q.gain == 5'h18) |=> (clk_gain_step == 3'h0) && clk_gain_code_ok;
  endproperty
  a_gain_min: assert property (p_gain_min)
    else $error("gain code 11000 not lowest step");

  property p_gain_def;
    (st_q.gain == 5'h00) |=> (clk_gain_step == 3'h1) && clk_gain_code_ok;
  endproperty
  a_gain_def: assert property (p_gain_def)
    else $error("gain code 00000 not step one");

  property p_gain_steps;
    ((st_q.gain == 5'h0c) |=> (clk_gain_step == 3'h2)) and
    ((st_q.gain == 5'h0a) |=> (clk_gain_step == 3'h3)) and
    ((st_q.gain == 5'h09) |=> (clk_gain_step == 3'h4)) and
    ((st_q.gain == 5'h08) |=> (clk_gain_step == 3'h5));
  endproperty
  a_gain_steps: assert property (p_gain_steps)
    else $error("gain step decode wrong");

  property p_normal;
    (st_q.src == 3'h0) && sample_valid |=> out_valid &&
      (out_word == {$past(sample_data[13]) ^ $past(st_q.output_number_coding),
                    $past(sample_data[12:0])});
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal data not passed");

  property p_const;
    ((st_q.src == 3'h1) && sample_valid |=> out_word == 14'h0000) and
    ((st_q.src == 3'h2) && sample_valid |=> out_word == 14'h3fff);
  endproperty
  a_const: assert property (p_const)
    else $error("constant pattern wrong");

  property p_toggle;
    s_tog_two |=> (out_word == ~$past(out_word)) && (out_word != 14'h0000);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle words not complementary");

  property p_unused;
    (st_q.src == 3'h4) && sample_valid |=> out_word == 14'h0000;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused source code not zero");

  property p_custom;
    (st_q.src == 3'h5) && sample_valid |=> out_word == {$past(st_q.uhi), $past(st_q.ulo)};
  endproperty
  a_custom: assert property (p_custom)
    else $error("custom word wrong");

  property p_align;
    (st_q.src == 3'h6) && sample_valid |=> out_word == 14'h2aaa;
  endproperty
  a_align: assert property (p_align)
    else $error("alignment stream wrong");

  property p_sync;
    (st_q.src == 3'h7) && sample_valid |=> out_word == SYNC_WORD;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync pattern wrong");

  property p_fmt_wr;
    s_wr_done(`ACR_ADDR_SRC) |=> st_q.output_number_coding == $past(pwdata[`ACR_FMT_BIT]);
  endproperty
  a_fmt_wr: assert property (p_fmt_wr)
    else $error("format bit not written");

  property p_ulo_wr;
    s_wr_done(`ACR_ADDR_ULO) |=> st_q.ulo == $past(pwdata[`ACR_ULO_MSB:0]);
  endproperty
  a_ulo_wr: assert property (p_ulo_wr)
    else $error("user low word not written");

  property p_uhi_wr;
    s_wr_done(`ACR_ADDR_UHI) |=> st_q.uhi == $past(pwdata[`ACR_UHI_MSB:0]);
  endproperty
  a_uhi_wr: assert property (p_uhi_wr)
    else $error("user high bits not written");

endmodule

`default_nettype wire

/* verif/test_acr_regs.sv */
// Self-checking bench for the ADC config register slice
`timescale 1ns/1ns
`default_nettype none
`include "acr_cfg.svh"

module test_acr_regs;
  localparam logic [13:0] SYNC_W = 14'h2c71; // Arbitrary sync word for the run

  logic        clock;
  logic        reset;
  logic        soft_reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sample_valid;
  logic [13:0] sample_data;
  logic        out_valid;
  logic [13:0] out_word;
  logic [2:0]  clk_gain_step;
  logic        clk_gain_code_ok;
  int          n_fail;
  int          tests_run;
  int          cycles;

  acr_regs #(.SYNC_WORD(SYNC_W)) u_acr_regs (
    .clock(clock), .reset(reset), .soft_reset(soft_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_data(sample_data), .out_valid(out_valid),
    .out_word(out_word), .clk_gain_step(clk_gain_step),
    .clk_gain_code_ok(clk_gain_code_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("apb answer", 32'(pready), 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(name, rd, exp);
  endtask

  // One converter sample; returns the word shown one cycle later
  task automatic samp(input logic [13:0] d, output logic [13:0] w);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_data  <= d;
    @(posedge clock);
    sample_valid <= 1'b0;
    @(posedge clock);
    check("out_valid", 32'(out_valid), 32'h1);
    w = out_word;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rchk("src reset", `ACR_ADDR_SRC, 32'h0);
    rchk("gain reset", `ACR_ADDR_GAIN, 32'h0);
    rchk("ulo reset", `ACR_ADDR_ULO, 32'h0);
    rchk("uhi reset", `ACR_ADDR_UHI, 32'h0);
    rchk("status reset", `ACR_ADDR_STAT, 32'h9);
    check("step port reset", 32'(clk_gain_step), 32'h1);
  endtask

  task automatic t_gain();
    logic [4:0] codes [6] = '{5'h18, 5'h00, 5'h0c, 5'h0a, 5'h09, 5'h08};
    for (int i = 5; i >= 0; i--) begin
      wr(`ACR_ADDR_GAIN, 32'(codes[i]) << 2);
      repeat (2) @(posedge clock);
      check("step port", 32'(clk_gain_step), 32'(i));
      check("code ok port", 32'(clk_gain_code_ok), 32'h1);
      rchk("status step", `ACR_ADDR_STAT, 32'h8 | 32'(i));
    end
    wr(`ACR_ADDR_GAIN, 32'hffffffff);
    rchk("gain field only", `ACR_ADDR_GAIN, 32'h7c);
    rchk("unlisted code", `ACR_ADDR_STAT, 32'h1);
    wr(`ACR_ADDR_GAIN, 32'h0);
  endtask

  task automatic t_src();
    logic [2:0]  c [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
    logic [13:0] e [5] = '{14'h0000, 14'h3fff, 14'h0000, 14'h2aaa, SYNC_W};
    logic [13:0] w;
    for (int i = 0; i < 5; i++) begin
      wr(`ACR_ADDR_SRC, 32'(c[i]) << 5);
      rchk("src readback", `ACR_ADDR_SRC, 32'(c[i]) << 5);
      samp(14'h1234, w);
      check("pattern word", 32'(w), 32'(e[i]));
    end
  endtask

  task automatic t_fmt();
    logic [13:0] w;
    wr(`ACR_ADDR_SRC, 32'h0);
    samp(14'h0123, w);
    check("normal twos", 32'(w), 32'h0123);
    samp(14'h2001, w);
    check("normal twos neg", 32'(w), 32'h2001);
    wr(`ACR_ADDR_SRC, 32'hffffffff);
    rchk("src fields only", `ACR_ADDR_SRC, 32'h2e0);
    wr(`ACR_ADDR_SRC, 32'h200);
    samp(14'h0123, w);
    check("straight binary", 32'(w), 32'h2123);
  endtask

  task automatic t_toggle();
    logic [13:0] a;
    logic [13:0] b;
    wr(`ACR_ADDR_SRC, 32'h60);
    samp(14'h0000, a);
    samp(14'h0000, b);
    check("toggle complement", 32'(a ^ b), 32'h3fff);
    check("toggle word", 32'(a == 14'h1555 || a == 14'h2aaa), 32'h1);
  endtask

  task automatic t_custom();
    logic [13:0] w;
    wr(`ACR_ADDR_ULO, 32'hfffffda5);
    wr(`ACR_ADDR_UHI, 32'hfffffffe);
    rchk("user low", `ACR_ADDR_ULO, 32'h5a5);
    rchk("user high", `ACR_ADDR_UHI, 32'h6);
    wr(`ACR_ADDR_SRC, 32'ha0);
    samp(14'h0000, w);
    check("custom word", 32'(w), 32'h35a5);
    // Partial strobe: only byte one of the user low word is written
    @(posedge clock);
    pstrb <= 4'h2;
    wr(`ACR_ADDR_ULO, 32'h0);
    pstrb <= 4'hf;
    rchk("user low strobe", `ACR_ADDR_ULO, 32'h0a5);
  endtask

  task automatic t_refuse();
    logic [31:0] rd;
    logic        err;
    apb(1'b0, 8'h08, 32'h0, rd, err);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, `ACR_ADDR_STAT, 32'h0, rd, err);
    check("status write err", 32'(err), 32'h1);
    rchk("status kept", `ACR_ADDR_STAT, 32'h9);
  endtask

  task automatic t_soft();
    wr(`ACR_ADDR_GAIN, 32'h60);
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    rchk("src soft", `ACR_ADDR_SRC, 32'h0);
    rchk("gain soft", `ACR_ADDR_GAIN, 32'h0);
    rchk("ulo soft", `ACR_ADDR_ULO, 32'h0);
    rchk("uhi soft", `ACR_ADDR_UHI, 32'h0);
    rchk("status soft", `ACR_ADDR_STAT, 32'h9);
    // Hardware reset in mid-run over programmed registers
    wr(`ACR_ADDR_SRC, 32'h2a0);
    wr(`ACR_ADDR_ULO, 32'h7ff);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    rchk("src hw reset", `ACR_ADDR_SRC, 32'h0);
    rchk("ulo hw reset", `ACR_ADDR_ULO, 32'h0);
    check("step port hw reset", 32'(clk_gain_step), 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    soft_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    sample_valid = 1'b0;
    sample_data = 14'h0000;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_gain();
    t_src();
    t_fmt();
    t_toggle();
    t_custom();
    t_refuse();
    t_soft();
    test_done();
  end
endmodule
`default_nettype wire
